// ### hdl/bit_shift_flag_exec_unit.sv
// Execution unit for interrupt-flag branches, I/O bit ops, shifts, flag ops and simple moves.
`timescale 1ns/10ps
module bit_shift_flag_exec_unit
  import exec_unit_pkg::*;
(
  // Clock and reset
  input  wire logic                                   clk_sys,
  input  wire logic                                   arst_n,
  // Issue of one operation
  input  wire logic                                   op_valid,
  input  wire exec_unit_pkg::op_t                     op_code,
  input  wire logic [exec_unit_pkg::REG_IDX_W-1:0]    op_dst,
  input  wire logic [exec_unit_pkg::REG_IDX_W-1:0]    op_src,
  input  wire logic [exec_unit_pkg::BIT_IDX_W-1:0]    op_bit,
  input  wire logic [exec_unit_pkg::DATA_W-1:0]       op_imm,
  input  wire logic [exec_unit_pkg::OFFS_W-1:0]       op_offset,
  input  wire logic [exec_unit_pkg::PC_W-1:0]         op_pc,
  input  wire logic [exec_unit_pkg::IO_ADDR_W-1:0]    op_io_addr,
  output logic                                        op_ready_r,
  output logic                                        retire_r,
  // Branch redirect
  output logic                                        br_taken_r,
  output logic      [exec_unit_pkg::PC_W-1:0]         br_target_r,
  // I/O register space
  output logic      [exec_unit_pkg::IO_ADDR_W-1:0]    io_addr_r,
  output logic                                        io_rd_r,
  input  wire logic [exec_unit_pkg::DATA_W-1:0]       io_rdata,
  output logic                                        io_wr_r,
  output logic      [exec_unit_pkg::DATA_W-1:0]       io_wdata_r,
  // Data memory read
  output logic      [exec_unit_pkg::DM_ADDR_W-1:0]    dm_addr_r,
  output logic                                        dm_rd_r,
  input  wire logic [exec_unit_pkg::DATA_W-1:0]       dm_rdata,
  // Status flags
  output logic      [exec_unit_pkg::DATA_W-1:0]       status_r
);

  import exec_unit_pkg::*;

  // Applies the write of the previous edge to stale read data of the same pair.
  function automatic logic [PAIR_W-1:0] fwd(
    input logic [PAIR_IDX_W-1:0] rd_addr,
    input logic [PAIR_W-1:0]     rd_data,
    input logic                  w_en,
    input logic [PAIR_IDX_W-1:0] w_addr,
    input logic [1:0]            w_be,
    input logic [PAIR_W-1:0]     w_data
  );
    logic [PAIR_W-1:0] v;
    v = rd_data;
    if (w_en && (w_addr == rd_addr)) begin
      if (w_be[0]) v[DATA_W-1:0] = w_data[DATA_W-1:0];
      if (w_be[1]) v[PAIR_W-1:DATA_W] = w_data[PAIR_W-1:DATA_W];
    end
    return v;
  endfunction : fwd

  // Operations that hold the issue slot for a second cycle.
  function automatic logic two_cycle(input op_t op, input logic irq);
    return (op == OP_IO_BIT_SET) || (op == OP_IO_BIT_CLEAR) ||
           (op == OP_LOAD_VIA_POINTER) ||
           ((op == OP_BRANCH_IF_IRQ_ON) && irq) ||
           ((op == OP_BRANCH_IF_IRQ_OFF) && !irq);
  endfunction : two_cycle

  // Shift group: returns the outgoing carry above the result byte.
  function automatic logic [DATA_W:0] shifter(input op_t op, input logic [DATA_W-1:0] d,
                                              input logic c);
    logic [DATA_W:0] v;
    v = {c, d};
    unique case (op)
      OP_SHIFT_LEFT_LOGICAL:  v = {d[7], d[6:0], 1'b0};
      OP_SHIFT_RIGHT_LOGICAL: v = {d[0], 1'b0, d[7:1]};
      OP_ROTATE_LEFT_CARRY:   v = {d[7], d[6:0], c};
      OP_ROTATE_RIGHT_CARRY:  v = {d[0], c, d[7:1]};
      OP_SHIFT_RIGHT_ARITH:   v = {d[0], d[7], d[7:1]};
      default:                v = {c, d};
    endcase
    return v;
  endfunction : shifter

  // Issue stage registers.
  state_t                  state_r;
  state_t                  state_nxt;
  logic                    ex_valid_r;
  op_t                     ex_op_r;
  logic [REG_IDX_W-1:0]    ex_dst_r;
  logic [REG_IDX_W-1:0]    ex_src_r;
  logic [BIT_IDX_W-1:0]    ex_bit_r;
  logic [DATA_W-1:0]       ex_imm_r;
  logic [OFFS_W-1:0]       ex_off_r;
  logic [PC_W-1:0]         ex_pc_r;

  // Register file ports and the record of the last write.
  logic [PAIR_IDX_W-1:0]   rf_a_addr;
  logic [PAIR_IDX_W-1:0]   rf_b_addr;
  logic [PAIR_W-1:0]       rf_a_data;
  logic [PAIR_W-1:0]       rf_b_data;
  logic                    wr_en;
  logic [PAIR_IDX_W-1:0]   wr_addr;
  logic [1:0]              wr_be;
  logic [PAIR_W-1:0]       wr_data;
  logic                    lw_en_r;
  logic [PAIR_IDX_W-1:0]   lw_addr_r;
  logic [1:0]              lw_be_r;
  logic [PAIR_W-1:0]       lw_data_r;

  // Execute stage values.
  logic                    accept;
  logic                    ex_two;
  logic                    ld_wb;
  logic [PAIR_W-1:0]       a_pair;
  logic [PAIR_W-1:0]       b_pair;
  logic [PAIR_IDX_W-1:0]   ex_b_addr;
  logic [DATA_W-1:0]       d_byte;
  logic [DATA_W-1:0]       r_byte;
  logic [DATA_W:0]         sh;
  logic [DATA_W-1:0]       res;
  logic                    is_shift;
  logic                    is_byte_wr;
  logic                    is_pair_wr;
  logic                    irq_flag;
  logic [DATA_W-1:0]       bit_mask;
  logic [DATA_W-1:0]       shift_flags;
  logic [DATA_W-1:0]       status_nxt;
  logic [PC_W-1:0]         off_ext;
  logic [PC_W-1:0]         br_target_nxt;
  logic                    br_taken_nxt;

  gpr_pair_mem #(
    .PAIRS  (REG_PAIRS),
    .BYTE_W (DATA_W),
    .ADDR_W (PAIR_IDX_W)
  ) u_gpr (
    .clk_sys     (clk_sys),
    .rd_a_addr   (rf_a_addr),
    .rd_a_data_r (rf_a_data),
    .rd_b_addr   (rf_b_addr),
    .rd_b_data_r (rf_b_data),
    .wr_en       (wr_en),
    .wr_addr     (wr_addr),
    .wr_be       (wr_be),
    .wr_data     (wr_data)
  );

  // Operands are read on the accepting edge and used in the following cycle.
  assign accept    = op_valid && op_ready_r;
  assign rf_a_addr = op_dst[REG_IDX_W-1:1];
  assign rf_b_addr = (op_code == OP_LOAD_VIA_POINTER) ? PTR_X_PAIR : op_src[REG_IDX_W-1:1];

  assign a_pair = fwd(ex_dst_r[REG_IDX_W-1:1], rf_a_data, lw_en_r, lw_addr_r, lw_be_r, lw_data_r);
  // The pointer load reads a fixed pair, so forwarding has to compare against that pair.
  assign ex_b_addr = (ex_op_r == OP_LOAD_VIA_POINTER) ? PTR_X_PAIR : ex_src_r[REG_IDX_W-1:1];
  assign b_pair = fwd(ex_b_addr, rf_b_data, lw_en_r, lw_addr_r, lw_be_r, lw_data_r);
  assign d_byte = ex_dst_r[0] ? a_pair[PAIR_W-1:DATA_W] : a_pair[DATA_W-1:0];
  assign r_byte = ex_src_r[0] ? b_pair[PAIR_W-1:DATA_W] : b_pair[DATA_W-1:0];
  assign bit_mask = 8'h01 << ex_bit_r;
  assign irq_flag = status_r[FLAG_I];

  // Shift group and its flags; overflow is N xor C and sign is N xor V.
  assign is_shift = (ex_op_r == OP_SHIFT_LEFT_LOGICAL) || (ex_op_r == OP_SHIFT_RIGHT_LOGICAL) ||
                    (ex_op_r == OP_ROTATE_LEFT_CARRY) || (ex_op_r == OP_ROTATE_RIGHT_CARRY) ||
                    (ex_op_r == OP_SHIFT_RIGHT_ARITH);
  assign sh = shifter(ex_op_r, d_byte, status_r[FLAG_C]);

  always_comb begin
    shift_flags          = status_r;
    shift_flags[FLAG_C]  = sh[DATA_W];
    shift_flags[FLAG_Z]  = (sh[DATA_W-1:0] == 8'h00);
    shift_flags[FLAG_N]  = sh[DATA_W-1];
    shift_flags[FLAG_V]  = sh[DATA_W-1] ^ sh[DATA_W];
    shift_flags[FLAG_S]  = sh[DATA_W];
  end

  // Byte result of every operation that writes one destination register, except the pointer load.
  assign res = is_shift                             ? sh[DATA_W-1:0] :
               (ex_op_r == OP_SWAP_NIBBLES)         ? {d_byte[3:0], d_byte[7:4]} :
               (ex_op_r == OP_TRANSFER_FLAG_TO_BIT) ?
                 (status_r[FLAG_T] ? (d_byte | bit_mask) : (d_byte & ~bit_mask)) :
               (ex_op_r == OP_REGISTER_COPY)        ? r_byte :
               ex_imm_r;

  assign is_byte_wr = ex_valid_r && (is_shift || (ex_op_r == OP_SWAP_NIBBLES) ||
                      (ex_op_r == OP_TRANSFER_FLAG_TO_BIT) || (ex_op_r == OP_REGISTER_COPY) ||
                      (ex_op_r == OP_LOAD_CONSTANT));
  assign is_pair_wr = ex_valid_r && (ex_op_r == OP_REGISTER_PAIR_COPY);
  assign ld_wb      = (state_r == ST_EXTRA) && (ex_op_r == OP_LOAD_VIA_POINTER);

  // Register file write port.
  assign wr_en   = is_byte_wr || is_pair_wr || ld_wb;
  assign wr_addr = ex_dst_r[REG_IDX_W-1:1];
  assign wr_be   = is_pair_wr ? BE_BOTH : (ex_dst_r[0] ? BE_HIGH : BE_LOW);
  assign wr_data = is_pair_wr ? b_pair :
                   ld_wb      ? {dm_rdata, dm_rdata} :
                   {res, res};

  // Status update: only the named flag changes for the flag operations.
  assign status_nxt =
    !ex_valid_r                             ? status_r :
    is_shift                                ? shift_flags :
    (ex_op_r == OP_FLAG_SET_BY_INDEX)       ? (status_r | bit_mask) :
    (ex_op_r == OP_FLAG_CLEAR_BY_INDEX)     ? (status_r & ~bit_mask) :
    (ex_op_r == OP_BIT_TO_TRANSFER_FLAG)    ?
      ((status_r & ~(8'h01 << FLAG_T)) | ({7'h00, |(r_byte & bit_mask)} << FLAG_T)) :
    status_r;

  // Branch target is the operation's own address plus the signed offset plus one.
  assign off_ext       = {{(PC_W-OFFS_W){ex_off_r[OFFS_W-1]}}, ex_off_r};
  assign br_target_nxt = ex_pc_r + off_ext + 16'h0001;
  assign br_taken_nxt  = ex_valid_r &&
                         (((ex_op_r == OP_BRANCH_IF_IRQ_ON) && irq_flag) ||
                          ((ex_op_r == OP_BRANCH_IF_IRQ_OFF) && !irq_flag));

  // The taken test at issue uses the flags that the previous operation is writing.
  assign ex_two    = ex_valid_r && two_cycle(ex_op_r, irq_flag);
  assign state_nxt = ex_two ? ST_EXTRA : ST_RUN;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_r    <= ST_RUN;
      ex_valid_r <= 1'b0;
      op_ready_r <= 1'b1;
      retire_r   <= 1'b0;
      status_r   <= STATUS_RST;
    end else begin
      state_r    <= state_nxt;
      ex_valid_r <= accept;
      op_ready_r <= !(accept && two_cycle(op_code, status_nxt[FLAG_I]));
      retire_r   <= (ex_valid_r && !ex_two) || (state_r == ST_EXTRA);
      status_r   <= status_nxt;
    end
  end

  // Operation fields are held until the next operation is taken.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ex_op_r  <= OP_NOP;
      ex_dst_r <= '0;
      ex_src_r <= '0;
      ex_bit_r <= '0;
      ex_imm_r <= '0;
      ex_off_r <= '0;
      ex_pc_r  <= '0;
    end else if (accept) begin
      ex_op_r  <= op_code;
      ex_dst_r <= op_dst;
      ex_src_r <= op_src;
      ex_bit_r <= op_bit;
      ex_imm_r <= op_imm;
      ex_off_r <= op_offset;
      ex_pc_r  <= op_pc;
    end
  end

  // Last register write, kept one cycle for forwarding.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      lw_en_r   <= 1'b0;
      lw_addr_r <= '0;
      lw_be_r   <= '0;
      lw_data_r <= '0;
    end else begin
      lw_en_r   <= wr_en;
      lw_addr_r <= wr_addr;
      lw_be_r   <= wr_be;
      lw_data_r <= wr_data;
    end
  end

  // Branch redirect pulse.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      br_taken_r  <= 1'b0;
      br_target_r <= '0;
    end else begin
      br_taken_r  <= br_taken_nxt;
      if (br_taken_nxt) begin
        br_target_r <= br_target_nxt;
      end
    end
  end

  // Read-modify-write of one I/O bit: read in the first cycle, write in the second.
  // Only the selected bit changes; the status flags are not touched.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      io_addr_r  <= '0;
      io_rd_r    <= 1'b0;
      io_wr_r    <= 1'b0;
      io_wdata_r <= '0;
    end else begin
      io_rd_r <= accept && ((op_code == OP_IO_BIT_SET) || (op_code == OP_IO_BIT_CLEAR));
      io_wr_r <= ex_valid_r && ((ex_op_r == OP_IO_BIT_SET) || (ex_op_r == OP_IO_BIT_CLEAR));
      if (accept) begin
        io_addr_r <= op_io_addr;
      end
      if (ex_valid_r && (ex_op_r == OP_IO_BIT_SET)) begin
        io_wdata_r <= io_rdata | bit_mask;
      end else if (ex_valid_r && (ex_op_r == OP_IO_BIT_CLEAR)) begin
        io_wdata_r <= io_rdata & ~bit_mask;
      end
    end
  end

  // The pointer comes from the register file, so the memory read starts a cycle after issue.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      dm_addr_r <= '0;
      dm_rd_r   <= 1'b0;
    end else begin
      dm_rd_r <= ex_valid_r && (ex_op_r == OP_LOAD_VIA_POINTER);
      if (ex_valid_r && (ex_op_r == OP_LOAD_VIA_POINTER)) begin
        dm_addr_r <= b_pair;
      end
    end
  end

endmodule : bit_shift_flag_exec_unit

// ### shared/exec_unit_pkg.sv
// Constants, opcodes and states shared by the bit, shift and flag execution unit.
package exec_unit_pkg;

  // Widths of the datapath and of the instruction fields.
  localparam int DATA_W     = 8;
  localparam int PAIR_W     = 16;
  localparam int REG_IDX_W  = 5;
  localparam int PAIR_IDX_W = 4;
  localparam int BIT_IDX_W  = 3;
  localparam int IO_ADDR_W  = 5;
  localparam int PC_W       = 16;
  localparam int OFFS_W     = 7;
  localparam int DM_ADDR_W  = 16;
  localparam int REG_PAIRS  = 16;

  // The first pointer pair lives in registers 26 and 27.
  localparam logic [PAIR_IDX_W-1:0] PTR_X_PAIR = 4'hD;

  // Positions of the flags in the status register.
  localparam logic [BIT_IDX_W-1:0] FLAG_C = 3'h0;
  localparam logic [BIT_IDX_W-1:0] FLAG_Z = 3'h1;
  localparam logic [BIT_IDX_W-1:0] FLAG_N = 3'h2;
  localparam logic [BIT_IDX_W-1:0] FLAG_V = 3'h3;
  localparam logic [BIT_IDX_W-1:0] FLAG_S = 3'h4;
  localparam logic [BIT_IDX_W-1:0] FLAG_H = 3'h5;
  localparam logic [BIT_IDX_W-1:0] FLAG_T = 3'h6;
  localparam logic [BIT_IDX_W-1:0] FLAG_I = 3'h7;

  // Values after reset.
  localparam logic [DATA_W-1:0] STATUS_RST = 8'h00;

  // Byte enables of the register pair write port.
  localparam logic [1:0] BE_LOW  = 2'h1;
  localparam logic [1:0] BE_HIGH = 2'h2;
  localparam logic [1:0] BE_BOTH = 2'h3;

  // Operations accepted by the unit.
  typedef enum logic [4:0] {
    OP_NOP,
    OP_BRANCH_IF_IRQ_ON,
    OP_BRANCH_IF_IRQ_OFF,
    OP_IO_BIT_SET,
    OP_IO_BIT_CLEAR,
    OP_SHIFT_LEFT_LOGICAL,
    OP_SHIFT_RIGHT_LOGICAL,
    OP_ROTATE_LEFT_CARRY,
    OP_ROTATE_RIGHT_CARRY,
    OP_SHIFT_RIGHT_ARITH,
    OP_SWAP_NIBBLES,
    OP_FLAG_SET_BY_INDEX,
    OP_FLAG_CLEAR_BY_INDEX,
    OP_BIT_TO_TRANSFER_FLAG,
    OP_TRANSFER_FLAG_TO_BIT,
    OP_REGISTER_COPY,
    OP_REGISTER_PAIR_COPY,
    OP_LOAD_CONSTANT,
    OP_LOAD_VIA_POINTER
  } op_t;

  typedef enum logic {
    ST_RUN,
    ST_EXTRA
  } state_t;

endpackage : exec_unit_pkg

// ### hdl/gpr_pair_mem.sv
// Working register file organised as byte pairs with two registered read ports.
`timescale 1ns/10ps
module gpr_pair_mem #(
  parameter int PAIRS  = exec_unit_pkg::REG_PAIRS,
  parameter int BYTE_W = exec_unit_pkg::DATA_W,
  parameter int ADDR_W = exec_unit_pkg::PAIR_IDX_W
) (
  // Clock
  input  wire logic                clk_sys,
  // Read port A
  input  wire logic [ADDR_W-1:0]   rd_a_addr,
  output logic      [2*BYTE_W-1:0] rd_a_data_r,
  // Read port B
  input  wire logic [ADDR_W-1:0]   rd_b_addr,
  output logic      [2*BYTE_W-1:0] rd_b_data_r,
  // Write port with one enable per byte
  input  wire logic                wr_en,
  input  wire logic [ADDR_W-1:0]   wr_addr,
  input  wire logic [1:0]          wr_be,
  input  wire logic [2*BYTE_W-1:0] wr_data
);

  // Reads see the contents before a write on the same edge; the user forwards.
  for (genvar lane = 0; lane < 2; lane++) begin : g_lane
    logic [BYTE_W-1:0] mem [PAIRS];

    always_ff @(posedge clk_sys) begin
      if (wr_en && wr_be[lane]) begin
        mem[wr_addr] <= wr_data[lane*BYTE_W +: BYTE_W];
      end
      rd_a_data_r[lane*BYTE_W +: BYTE_W] <= mem[rd_a_addr];
      rd_b_data_r[lane*BYTE_W +: BYTE_W] <= mem[rd_b_addr];
    end
  end

endmodule : gpr_pair_mem

// ### test/exec_unit_chk.sv
// Port-level assertions for the bit, shift and flag execution unit.
`timescale 1ns/10ps
module exec_unit_chk
  import exec_unit_pkg::*;
(
  // Clock and reset
  input wire logic                 clk_sys,
  input wire logic                 arst_n,
  // Issue side
  input wire logic                 op_valid,
  input wire exec_unit_pkg::op_t   op_code,
  input wire logic [2:0]           op_bit,
  input wire logic [6:0]           op_offset,
  input wire logic [15:0]          op_pc,
  input wire logic                 op_ready_r,
  input wire logic                 retire_r,
  // Branch, I/O, memory and flags
  input wire logic                 br_taken_r,
  input wire logic [15:0]          br_target_r,
  input wire logic                 io_rd_r,
  input wire logic [7:0]           io_rdata,
  input wire logic                 io_wr_r,
  input wire logic [7:0]           io_wdata_r,
  input wire logic                 dm_rd_r,
  input wire logic [7:0]           status_r
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  logic acc_q_r;
  wire  acc    = op_valid && op_ready_r;
  // Flag checks only start when no result of an earlier issue is still landing.
  wire  calm   = acc && !acc_q_r;
  wire  is_br  = (op_code == OP_BRANCH_IF_IRQ_ON) || (op_code == OP_BRANCH_IF_IRQ_OFF);
  wire  br_go  = (op_code == OP_BRANCH_IF_IRQ_ON) ? status_r[FLAG_I] : !status_r[FLAG_I];
  wire  is_sh  = op_code inside {OP_SHIFT_LEFT_LOGICAL, OP_SHIFT_RIGHT_LOGICAL, OP_ROTATE_LEFT_CARRY,
                                 OP_ROTATE_RIGHT_CARRY, OP_SHIFT_RIGHT_ARITH};
  wire  keep   = op_code inside {OP_SWAP_NIBBLES, OP_TRANSFER_FLAG_TO_BIT, OP_REGISTER_COPY,
                                 OP_REGISTER_PAIR_COPY, OP_LOAD_CONSTANT};
  wire [15:0] br_exp = op_pc + {{9{op_offset[6]}}, op_offset} + 16'h0001;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      acc_q_r <= 1'b0;
    end else begin
      acc_q_r <= acc;
    end
  end

  property p_br_taken;
    calm && is_br && br_go |=> !op_ready_r ##1 (br_taken_r && br_target_r == $past(br_exp, 2)) ##1 retire_r;
  endproperty
  a_br_taken: assert property (p_br_taken) else $error("taken branch wrong target or timing");
  property p_br_skip;
    calm && is_br && !br_go |=> op_ready_r ##1 (retire_r && !br_taken_r);
  endproperty
  a_br_skip: assert property (p_br_skip) else $error("untaken branch misbehaved");
  property p_io_set;
    calm && op_code == OP_IO_BIT_SET |=> (io_rd_r && !op_ready_r) ##1
      (io_wr_r && io_wdata_r == ($past(io_rdata) | (8'h01 << $past(op_bit, 2))) && status_r == $past(status_r, 2));
  endproperty
  a_io_set: assert property (p_io_set) else $error("io bit set wrong");
  property p_io_clr;
    calm && op_code == OP_IO_BIT_CLEAR |=> (io_rd_r && !op_ready_r) ##1
      (io_wr_r && io_wdata_r == ($past(io_rdata) & ~(8'h01 << $past(op_bit, 2))) && status_r == $past(status_r, 2));
  endproperty
  a_io_clr: assert property (p_io_clr) else $error("io bit clear wrong");
  property p_shift_flags;
    calm && is_sh |-> ##2 ($stable(status_r[7:5]) && status_r[FLAG_V] == (status_r[FLAG_N] ^ status_r[FLAG_C]));
  endproperty
  a_shift_flags: assert property (p_shift_flags) else $error("shift flags wrong");
  property p_flag_set;
    calm && op_code == OP_FLAG_SET_BY_INDEX |-> ##2 status_r == ($past(status_r, 2) | (8'h01 << $past(op_bit, 2)));
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag set wrong");
  property p_flag_clr;
    calm && op_code == OP_FLAG_CLEAR_BY_INDEX |-> ##2 status_r == ($past(status_r, 2) & ~(8'h01 << $past(op_bit, 2)));
  endproperty
  a_flag_clr: assert property (p_flag_clr) else $error("flag clear wrong");
  property p_bit_store;
    calm && op_code == OP_BIT_TO_TRANSFER_FLAG |-> ##2 (status_r & 8'hBF) == ($past(status_r, 2) & 8'hBF);
  endproperty
  a_bit_store: assert property (p_bit_store) else $error("bit store touched other flags");
  property p_keep;
    calm && keep |-> ##2 status_r == $past(status_r, 2);
  endproperty
  a_keep: assert property (p_keep) else $error("flags changed by move");
  property p_ptr;
    acc && op_code == OP_LOAD_VIA_POINTER |=> !op_ready_r ##1 (dm_rd_r && op_ready_r) ##1 retire_r;
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer load timing wrong");

  c_br: cover property (calm && is_br && br_go);
  c_io: cover property (io_wr_r);
  c_dm: cover property (dm_rd_r);
endmodule : exec_unit_chk

// ### test/bit_shift_flag_exec_unit_tb.sv
// Directed self-checking bench for the bit, shift and flag execution unit.
`timescale 1ns/10ps
module bit_shift_flag_exec_unit_tb;
  import exec_unit_pkg::*;
  localparam int LIMIT = 3000;
  logic        clk_sys = 1'b0;
  logic        arst_n = 1'b0;
  logic        op_valid = 1'b0;
  op_t         op_code = OP_NOP;
  logic [4:0]  op_dst = 5'h00, op_src = 5'h00, op_io_addr = 5'h00, io_addr_r;
  logic [2:0]  op_bit = 3'h0;
  logic [7:0]  op_imm = 8'h00, io_rdata = 8'h00, dm_rdata = 8'h77, io_wdata_r, status_r, cap_wr, exp_st;
  logic [6:0]  op_offset = 7'h00;
  logic [15:0] op_pc = 16'h0000, br_target_r, dm_addr_r, cap_br, cap_dm;
  logic        op_ready_r, retire_r, br_taken_r, io_rd_r, io_wr_r, dm_rd_r, got_br;
  int          err_total = 0, compares = 0, cyc = 0, lat;

  bit_shift_flag_exec_unit dut_u (
    .clk_sys(clk_sys), .arst_n(arst_n), .op_valid(op_valid), .op_code(op_code), .op_dst(op_dst),
    .op_src(op_src), .op_bit(op_bit), .op_imm(op_imm), .op_offset(op_offset), .op_pc(op_pc),
    .op_io_addr(op_io_addr), .op_ready_r(op_ready_r), .retire_r(retire_r), .br_taken_r(br_taken_r),
    .br_target_r(br_target_r), .io_addr_r(io_addr_r), .io_rd_r(io_rd_r), .io_rdata(io_rdata),
    .io_wr_r(io_wr_r), .io_wdata_r(io_wdata_r), .dm_addr_r(dm_addr_r), .dm_rd_r(dm_rd_r),
    .dm_rdata(dm_rdata), .status_r(status_r));

  always #5 clk_sys = ~clk_sys;

  task automatic wrap_up();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : wrap_up

  // A hung handshake would otherwise stall the run forever.
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == LIMIT) begin
      err_total++;
      wrap_up();
    end
  end

  task automatic chk(logic [15:0] g, logic [15:0] e);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // Issues one operation, then follows it to retirement while capturing its side outputs.
  task automatic issue(op_t op, logic [4:0] d, logic [4:0] s, logic [2:0] b, logic [7:0] k);
    @(posedge clk_sys);
    #1;
    while (op_ready_r !== 1'b1) begin
      @(posedge clk_sys);
      #1;
    end
    op_code = op;
    op_dst = d;
    op_src = s;
    op_bit = b;
    op_imm = k;
    op_valid = 1'b1;
    got_br = 1'b0;
    cap_br = 'x;
    cap_wr = 'x;
    cap_dm = 'x;
    lat = 0;
    @(posedge clk_sys);
    #1;
    op_valid = 1'b0;
    while (retire_r !== 1'b1 && lat < 8) begin
      if (br_taken_r === 1'b1) begin
        got_br = 1'b1;
        cap_br = br_target_r;
      end
      if (io_wr_r === 1'b1) cap_wr = io_wdata_r;
      if (dm_rd_r === 1'b1) cap_dm = dm_addr_r;
      @(posedge clk_sys);
      #1;
      lat++;
    end
  endtask : issue

  task automatic ldk(logic [4:0] d, logic [7:0] k);
    issue(OP_LOAD_CONSTANT, d, 5'h00, 3'h0, k);
  endtask : ldk

  // The pointer load exposes the pointer pair on the memory address port.
  task automatic peek(logic [15:0] e);
    issue(OP_LOAD_VIA_POINTER, 5'h00, 5'h00, 3'h0, 8'h00);
    chk(cap_dm, e);
    chk(16'(lat), 16'h0002);
  endtask : peek

  task automatic sflag(logic [2:0] b, logic v);
    if (v) issue(OP_FLAG_SET_BY_INDEX, 5'h00, 5'h00, b, 8'h00);
    else issue(OP_FLAG_CLEAR_BY_INDEX, 5'h00, 5'h00, b, 8'h00);
    exp_st[b] = v;
    chk(status_r, exp_st);
    chk(16'(lat), 16'h0001);
  endtask : sflag

  task automatic t_shift(op_t op, logic [7:0] a, logic ci, logic [7:0] r, logic co);
    sflag(FLAG_C, ci);
    ldk(5'h1A, a);
    issue(op, 5'h1A, 5'h00, 3'h0, 8'h00);
    exp_st[0] = co;
    exp_st[1] = (r == 8'h00);
    exp_st[2] = r[7];
    exp_st[3] = r[7] ^ co;
    exp_st[4] = r[7] ^ exp_st[3];
    chk(status_r, exp_st);
    chk(16'(lat), 16'h0001);
    peek({8'h00, r});
  endtask : t_shift

  task automatic t_io(op_t op, logic [2:0] b, logic [7:0] e);
    io_rdata = 8'hA5;
    op_io_addr = 5'h0B;
    issue(op, 5'h00, 5'h00, b, 8'h00);
    chk(cap_wr, e);
    chk(16'(lat), 16'h0002);
    chk(io_addr_r, 5'h0B);
    chk(status_r, exp_st);
  endtask : t_io

  task automatic t_branch(op_t op, logic [15:0] pc, logic [6:0] off, logic tk, logic [15:0] e);
    op_pc = pc;
    op_offset = off;
    issue(op, 5'h00, 5'h00, 3'h0, 8'h00);
    chk(got_br, tk);
    chk(16'(lat), tk ? 16'h0002 : 16'h0001);
    if (tk) chk(cap_br, e);
  endtask : t_branch

  task automatic t_moves();
    ldk(5'h05, 8'h5A);
    issue(OP_REGISTER_COPY, 5'h1A, 5'h05, 3'h0, 8'h00);
    peek(16'h005A);
    ldk(5'h04, 8'h34);
    ldk(5'h05, 8'h12);
    issue(OP_REGISTER_PAIR_COPY, 5'h1A, 5'h04, 3'h0, 8'h00);
    chk(status_r, exp_st);
    peek(16'h1234);
    issue(OP_LOAD_VIA_POINTER, 5'h1A, 5'h00, 3'h0, 8'h00);
    peek(16'h1277);
    ldk(5'h1A, 8'h3C);
    issue(OP_SWAP_NIBBLES, 5'h1A, 5'h00, 3'h0, 8'h00);
    chk(status_r, exp_st);
    peek(16'h12C3);
  endtask : t_moves

  // A pointer load right behind a write to the pointer sees that write only through forwarding.
  task automatic t_b2b();
    @(posedge clk_sys);
    #1;
    op_code = OP_LOAD_CONSTANT;
    op_dst = 5'h1A;
    op_imm = 8'h4C;
    op_valid = 1'b1;
    @(posedge clk_sys);
    #1;
    op_code = OP_LOAD_VIA_POINTER;
    op_dst = 5'h00;
    @(posedge clk_sys);
    #1;
    op_valid = 1'b0;
    repeat (3) @(posedge clk_sys);
    #1;
    chk(dm_addr_r, 16'h124C);
  endtask : t_b2b

  initial begin
    exp_st = STATUS_RST;
    repeat (3) @(posedge clk_sys);
    #1;
    chk(op_ready_r, 1'b1);
    chk(status_r, STATUS_RST);
    arst_n = 1'b1;
    for (int i = 0; i < 8; i++) sflag(3'(i), 1'b1);
    for (int i = 0; i < 8; i++) sflag(3'(i), 1'b0);
    t_io(OP_IO_BIT_SET, 3'h1, 8'hA7);
    t_io(OP_IO_BIT_CLEAR, 3'h0, 8'hA4);
    t_io(OP_IO_BIT_CLEAR, 3'h7, 8'h25);
    sflag(FLAG_I, 1'b1);
    t_branch(OP_BRANCH_IF_IRQ_ON, 16'h0100, 7'h7E, 1'b1, 16'h00FF);
    t_branch(OP_BRANCH_IF_IRQ_OFF, 16'h0100, 7'h7E, 1'b0, 16'h0000);
    sflag(FLAG_I, 1'b0);
    t_branch(OP_BRANCH_IF_IRQ_OFF, 16'h1000, 7'h3F, 1'b1, 16'h1040);
    t_branch(OP_BRANCH_IF_IRQ_ON, 16'h1000, 7'h3F, 1'b0, 16'h0000);
    ldk(5'h1B, 8'h00);
    ldk(5'h1A, 8'h20);
    issue(OP_BIT_TO_TRANSFER_FLAG, 5'h00, 5'h1A, 3'h5, 8'h00);
    exp_st[FLAG_T] = 1'b1;
    chk(status_r, exp_st);
    issue(OP_BIT_TO_TRANSFER_FLAG, 5'h00, 5'h1A, 3'h4, 8'h00);
    exp_st[FLAG_T] = 1'b0;
    chk(status_r, exp_st);
    sflag(FLAG_T, 1'b1);
    issue(OP_TRANSFER_FLAG_TO_BIT, 5'h1A, 5'h00, 3'h0, 8'h00);
    chk(status_r, exp_st);
    peek(16'h0021);
    sflag(FLAG_T, 1'b0);
    issue(OP_TRANSFER_FLAG_TO_BIT, 5'h1A, 5'h00, 3'h5, 8'h00);
    peek(16'h0001);
    t_shift(OP_SHIFT_LEFT_LOGICAL, 8'h81, 1'b0, 8'h02, 1'b1);
    t_shift(OP_SHIFT_LEFT_LOGICAL, 8'h80, 1'b1, 8'h00, 1'b1);
    t_shift(OP_SHIFT_RIGHT_LOGICAL, 8'h81, 1'b1, 8'h40, 1'b1);
    t_shift(OP_ROTATE_LEFT_CARRY, 8'h80, 1'b1, 8'h01, 1'b1);
    t_shift(OP_ROTATE_LEFT_CARRY, 8'h7F, 1'b0, 8'hFE, 1'b0);
    t_shift(OP_ROTATE_RIGHT_CARRY, 8'h01, 1'b1, 8'h80, 1'b1);
    t_shift(OP_ROTATE_RIGHT_CARRY, 8'h00, 1'b0, 8'h00, 1'b0);
    t_shift(OP_SHIFT_RIGHT_ARITH, 8'h81, 1'b0, 8'hC0, 1'b1);
    t_shift(OP_SHIFT_RIGHT_ARITH, 8'h42, 1'b1, 8'h21, 1'b0);
    t_moves();
    t_b2b();
    wrap_up();
  end
endmodule : bit_shift_flag_exec_unit_tb

bind bit_shift_flag_exec_unit exec_unit_chk chk_u (
  .clk_sys(clk_sys), .arst_n(arst_n), .op_valid(op_valid), .op_code(op_code), .op_bit(op_bit),
  .op_offset(op_offset), .op_pc(op_pc), .op_ready_r(op_ready_r), .retire_r(retire_r),
  .br_taken_r(br_taken_r), .br_target_r(br_target_r), .io_rd_r(io_rd_r), .io_rdata(io_rdata),
  .io_wr_r(io_wr_r), .io_wdata_r(io_wdata_r), .dm_rd_r(dm_rd_r), .status_r(status_r));
